//--- design/sotp_regs.vh
// Behaviour
// RL1: The source selector resets to 00h (output unused, held low) and code 07h holds the output permanently high.
// RL2: Codes 01h to 04h put the STO, SS1, SOS and SS2 function states on the output.
// RL3: Code 05h puts the SLS state on the output and code 06h mirrors the brake-released state.
// RL4: After an internal off request the output stops delivering power within 4 ms.
// RL5: The read-back state is compared with the commanded state and a mismatch raises the output fault in bounded time.
// RL6: Each test pulse lasts 1 ms, within ten percent.
// RL7: While the output is high, a test pulse is generated about every 1100 ms, within ten percent.
// RL8: A failed test pulse raises the output fault.
// RL9: The connected input module tolerates the short low test pulses.
// RL10: The connected input module is advised to check that test pulses arrive.
// RL11: The output has two channels, A and B, driven together and both pulsed.
// RL12: During a pulse both channels are driven low and each read-back must follow, else a fault is flagged.
`ifndef SOTP_REGS_VH
`define SOTP_REGS_VH

`define SOTP_CLK_HZ 50000000
`define SOTP_OFF_DELAY_MS 4
`define SOTP_PULSE_US 1000
`define SOTP_PERIOD_MS 1100
`define SOTP_FAULT_REACT_US 500
`define SOTP_PULSE_CYC (`SOTP_CLK_HZ / 1000000 * `SOTP_PULSE_US)
`define SOTP_PERIOD_CYC (`SOTP_CLK_HZ / 1000 * `SOTP_PERIOD_MS)
`define SOTP_REACT_CYC (`SOTP_CLK_HZ / 1000000 * `SOTP_FAULT_REACT_US)
`define SOTP_SETTLE_CYC 32'h00000032

`define SOTP_OFS_SEL 8'h00
`define SOTP_OFS_FN 8'h04
`define SOTP_OFS_STAT 8'h08
`define SOTP_OFS_IRQ_STAT 8'h0c
`define SOTP_OFS_IRQ_MASK 8'h10

`define SOTP_SEL_RESET 8'h00
`define SOTP_SEL_UNUSED 8'h00
`define SOTP_SEL_STO 8'h01
`define SOTP_SEL_SS1 8'h02
`define SOTP_SEL_SOS 8'h03
`define SOTP_SEL_SS2 8'h04
`define SOTP_SEL_SLS 8'h05
`define SOTP_SEL_BRAKE 8'h06
`define SOTP_SEL_HIGH 8'h07

`define SOTP_IRQ_MISMATCH 0
`define SOTP_IRQ_PULSE 1
`define SOTP_IRQ_PULSE_DONE 2
`define SOTP_IRQ_W 3

`endif

//--- design/sotp_timer.v
// Down counter: loads on start, flags done for one cycle once the count is down to one.
module sotp_timer (
	input wire aclk, // Clock.
	input wire aresetn, // Synchronous reset, active low.
	input wire start, // Load pulse.
	input wire stop, // Abort the count.
	input wire [31:0] load_val, // Cycles to count.
	output reg done_ff, // One-cycle pulse when the count expires.
	output reg busy_ff // High while counting.
);
	reg [31:0] cnt_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff <= 32'h00000000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				cnt_ff <= load_val;
				busy_ff <= 1'b1;
			end else if (stop) begin
				busy_ff <= 1'b0;
			end else if (busy_ff) begin
				if (cnt_ff <= 32'h00000001) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - 32'h00000001;
				end
			end
		end
	end
endmodule // sotp_timer

//--- design/sotp_safe_out.v
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`include "sotp_regs.vh"

// Timing counts are parameters so that a bench can run them shortened.
module sotp_safe_out #(
	parameter [31:0] PERIOD_CYC = `SOTP_PERIOD_CYC, // Pulse spacing.
	parameter [31:0] PULSE_CYC = `SOTP_PULSE_CYC, // Pulse length.
	parameter [31:0] REACT_CYC = `SOTP_REACT_CYC // Mismatch tolerance.
) (
	input wire aclk, // Clock, 50 MHz.
	input wire aresetn, // Synchronous reset, active low.
	input wire [31:0] s_axi_awaddr, // Write address.
	input wire s_axi_awvalid, // Write address valid.
	output wire s_axi_awready, // Write address ready.
	input wire [31:0] s_axi_wdata, // Write data.
	input wire [3:0] s_axi_wstrb, // Write byte strobes.
	input wire s_axi_wvalid, // Write data valid.
	output wire s_axi_wready, // Write data ready.
	output reg [1:0] s_axi_bresp_ff, // Write response.
	output reg s_axi_bvalid_ff, // Write response valid.
	input wire s_axi_bready, // Write response ready.
	input wire [31:0] s_axi_araddr, // Read address.
	input wire s_axi_arvalid, // Read address valid.
	output wire s_axi_arready, // Read address ready.
	output reg [31:0] s_axi_rdata_ff, // Read data.
	output reg [1:0] s_axi_rresp_ff, // Read response.
	output reg s_axi_rvalid_ff, // Read data valid.
	input wire s_axi_rready, // Read data ready.
	input wire fn_sto, // STO function active.
	input wire fn_ss1, // SS1 function active.
	input wire fn_sos, // SOS function active.
	input wire fn_ss2, // SS2 function active.
	input wire fn_sls, // SLS function active.
	input wire fn_brake_rel, // Brake released.
	input wire rdbk_a, // Read-back of channel A.
	input wire rdbk_b, // Read-back of channel B.
	output reg out_a_ff, // Safe output channel A.
	output reg out_b_ff, // Safe output channel B.
	output reg safe_out_fault_ff, // Sticky fault reaction request.
	output wire irq // Level interrupt.
);
	localparam ST_IDLE = 3'b001;
	localparam ST_HIGH = 3'b010;
	localparam ST_PULSE = 3'b100;

	reg [7:0] sel_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg cmd_ff;
	reg [31:0] react_ff;
	reg [`SOTP_IRQ_W-1:0] irq_stat_ff;
	reg [`SOTP_IRQ_W-1:0] irq_mask_ff;
	reg pulse_ok_a_ff;
	reg pulse_ok_b_ff;
	reg [31:0] pulse_age_ff;
	reg aw_hold_ff;
	reg w_hold_ff;
	reg [31:0] awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	reg want;
	reg set_mis;
	reg set_pulse;
	reg set_done;
	wire per_start;
	wire per_done;
	wire pul_start;
	wire pul_done;
	wire wr_go;
	wire drive;

	function [7:0] word_idx;
		input [31:0] addr;
		begin
			word_idx = {addr[7:2], 2'b00};
		end
	endfunction

	// Source selection; unused and unknown codes keep the output low.
	always @* begin
		if (sel_ff == `SOTP_SEL_STO) want = fn_sto; // [RL2]
		else if (sel_ff == `SOTP_SEL_SS1) want = fn_ss1; // [RL2]
		else if (sel_ff == `SOTP_SEL_SOS) want = fn_sos; // [RL2]
		else if (sel_ff == `SOTP_SEL_SS2) want = fn_ss2; // [RL2]
		else if (sel_ff == `SOTP_SEL_SLS) want = fn_sls; // [RL3]
		else if (sel_ff == `SOTP_SEL_BRAKE) want = fn_brake_rel; // [RL3]
		else if (sel_ff == `SOTP_SEL_HIGH) want = 1'b1; // [RL1]
		else want = 1'b0; // [RL1]
	end

	// An off request drops the channels on the next edge, far inside 4 ms.
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (want && !safe_out_fault_ff) nxt_state = ST_HIGH;
			end
			ST_HIGH: begin
				if (!want || safe_out_fault_ff) nxt_state = ST_IDLE; // [RL4]
				else if (per_done) nxt_state = ST_PULSE; // [RL7]
			end
			ST_PULSE: begin
				if (!want || safe_out_fault_ff) nxt_state = ST_IDLE; // [RL4]
				else if (pul_done) nxt_state = ST_HIGH; // [RL6]
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	assign per_start = (state_ff != ST_HIGH) && (nxt_state == ST_HIGH);
	assign pul_start = (state_ff == ST_HIGH) && (nxt_state == ST_PULSE);
	assign drive = (nxt_state == ST_HIGH);

	sotp_timer u_period (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(per_start),
		.stop(state_ff != ST_HIGH),
		.load_val(PERIOD_CYC), // [RL7]
		.done_ff(per_done),
		.busy_ff()
	);

	sotp_timer u_pulse (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(pul_start),
		.stop(state_ff != ST_PULSE),
		.load_val(PULSE_CYC), // [RL6]
		.done_ff(pul_done),
		.busy_ff()
	);

	always @* begin
		set_mis = (react_ff >= REACT_CYC); // [RL5]
		set_pulse = (state_ff == ST_PULSE) && pul_done &&
			!(pulse_ok_a_ff && pulse_ok_b_ff); // [RL8]
		set_done = (state_ff == ST_PULSE) && pul_done;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			out_a_ff <= 1'b0;
			out_b_ff <= 1'b0;
			cmd_ff <= 1'b0;
			react_ff <= 32'h00000000;
			pulse_ok_a_ff <= 1'b0;
			pulse_ok_b_ff <= 1'b0;
			pulse_age_ff <= 32'h00000000;
			safe_out_fault_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			out_a_ff <= drive; // [RL11]
			out_b_ff <= drive; // [RL11]
			cmd_ff <= drive;
			// Read-back lags the driver, so a short mismatch is tolerated.
			if ((rdbk_a != cmd_ff) || (rdbk_b != cmd_ff)) begin
				if (react_ff < REACT_CYC) react_ff <= react_ff + 32'h00000001;
			end else begin
				react_ff <= 32'h00000000;
			end
			if (pul_start) begin
				pulse_ok_a_ff <= 1'b0;
				pulse_ok_b_ff <= 1'b0;
				pulse_age_ff <= 32'h00000000;
			end else if (state_ff == ST_PULSE) begin
				pulse_age_ff <= pulse_age_ff + 32'h00000001;
				// Each channel must read low once it has had time to settle.
				if (pulse_age_ff >= `SOTP_SETTLE_CYC) begin
					if (!rdbk_a) pulse_ok_a_ff <= 1'b1; // [RL12]
					if (!rdbk_b) pulse_ok_b_ff <= 1'b1; // [RL12]
				end
			end
			if (set_mis || set_pulse) safe_out_fault_ff <= 1'b1; // [RL5] [RL8]
		end
	end

	// AXI4-Lite slave; address and data may arrive in either order.
	assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid_ff;
	assign s_axi_wready = !w_hold_ff && !s_axi_bvalid_ff;
	assign s_axi_arready = !s_axi_rvalid_ff;
	assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid_ff;
	assign irq = |(irq_stat_ff & irq_mask_ff);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= 32'h00000000;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			s_axi_bvalid_ff <= 1'b0;
			s_axi_bresp_ff <= 2'b00;
			s_axi_rvalid_ff <= 1'b0;
			s_axi_rresp_ff <= 2'b00;
			s_axi_rdata_ff <= 32'h00000000;
			sel_ff <= `SOTP_SEL_RESET; // [RL1]
			irq_stat_ff <= {`SOTP_IRQ_W{1'b0}};
			irq_mask_ff <= {`SOTP_IRQ_W{1'b0}};
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (s_axi_bvalid_ff && s_axi_bready) s_axi_bvalid_ff <= 1'b0;
			// Hardware set wins over the write-one clear in the same cycle.
			irq_stat_ff <= irq_stat_ff | {set_done, set_pulse, set_mis};
			if (wr_go) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				s_axi_bvalid_ff <= 1'b1;
				s_axi_bresp_ff <= 2'b00;
				if (word_idx(awaddr_ff) == `SOTP_OFS_SEL) begin
					if (wstrb_ff[0]) sel_ff <= wdata_ff[7:0];
				end else if (word_idx(awaddr_ff) == `SOTP_OFS_IRQ_STAT) begin
					if (wstrb_ff[0])
						irq_stat_ff <= (irq_stat_ff &
							~wdata_ff[`SOTP_IRQ_W-1:0]) |
							{set_done, set_pulse, set_mis};
				end else if (word_idx(awaddr_ff) == `SOTP_OFS_IRQ_MASK) begin
					if (wstrb_ff[0]) irq_mask_ff <= wdata_ff[`SOTP_IRQ_W-1:0];
				end else if ((word_idx(awaddr_ff) != `SOTP_OFS_FN) &&
					(word_idx(awaddr_ff) != `SOTP_OFS_STAT)) begin
					s_axi_bresp_ff <= 2'b10;
				end
			end
			if (s_axi_rvalid_ff && s_axi_rready) s_axi_rvalid_ff <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid_ff <= 1'b1;
				s_axi_rresp_ff <= 2'b00;
				s_axi_rdata_ff <= 32'h00000000;
				if (word_idx(s_axi_araddr) == `SOTP_OFS_SEL) begin
					s_axi_rdata_ff <= {24'h000000, sel_ff};
				end else if (word_idx(s_axi_araddr) == `SOTP_OFS_FN) begin
					s_axi_rdata_ff <= {26'h0000000, fn_brake_rel, fn_sls,
						fn_ss2, fn_sos, fn_ss1, fn_sto};
				end else if (word_idx(s_axi_araddr) == `SOTP_OFS_STAT) begin
					s_axi_rdata_ff <= {24'h000000, state_ff, rdbk_b, rdbk_a,
						out_b_ff, out_a_ff, safe_out_fault_ff};
				end else if (word_idx(s_axi_araddr) == `SOTP_OFS_IRQ_STAT) begin
					s_axi_rdata_ff <= {29'h00000000, irq_stat_ff};
				end else if (word_idx(s_axi_araddr) == `SOTP_OFS_IRQ_MASK) begin
					s_axi_rdata_ff <= {29'h00000000, irq_mask_ff};
				end else begin
					s_axi_rresp_ff <= 2'b10;
				end
			end
		end
	end
endmodule // sotp_safe_out

//--- sim/sotp_safe_out_assertions.sv
module sotp_chk #(
	parameter int PERIOD_CYC = 2000, // Cycles between test pulses.
	parameter int REACT_CYC = 50 // Tolerated mismatch cycles.
) (
	input wire aclk, // Clock.
	input wire aresetn, // Reset, active low.
	input wire s_axi_arvalid, // Read address valid.
	input wire s_axi_arready, // Read address ready.
	input wire s_axi_bready, // Response ready.
	input wire s_axi_bvalid_ff, // Response valid.
	input wire s_axi_rready, // Read data ready.
	input wire s_axi_rvalid_ff, // Read data valid.
	input wire rdbk_a, // Read-back A.
	input wire out_a_ff, // Channel A.
	input wire out_b_ff, // Channel B.
	input wire safe_out_fault_ff // Fault.
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int hi_max = PERIOD_CYC * 11 / 10;
	// The fault drops the output and ends the mismatch, so the count only
	// just passes the tolerance; a limit above REACT_CYC + 2 would never be reached.
	localparam int mis_lim = REACT_CYC + 1;
	logic [31:0] hi_cnt_ff;
	logic [31:0] mis_cnt_ff;
	always_ff @(posedge aclk) begin
		hi_cnt_ff <= (!aresetn || !out_a_ff) ? 32'h0 : hi_cnt_ff + 32'h1;
		mis_cnt_ff <= (!aresetn || rdbk_a == out_a_ff) ? 32'h0
			: mis_cnt_ff + 32'h1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_answer;
		##1 s_axi_rvalid_ff;
	endsequence
	chk_reset_quiet: assert property (disable iff (1'b0)
		!aresetn |=> !out_a_ff && !safe_out_fault_ff) else $error("not quiet");
	chk_chan_pair: assert property (
		out_a_ff == out_b_ff) else $error("channels differ");
	chk_fault_sticky: assert property (
		safe_out_fault_ff |=> safe_out_fault_ff) else $error("fault lost");
	chk_fault_off: assert property (
		safe_out_fault_ff |-> ##2 !out_a_ff && !out_b_ff) else $error("on");
	chk_read_answer: assert property (
		rd_taken |-> rd_answer) else $error("read not answered");
	chk_write_done: assert property (
		s_axi_bvalid_ff && s_axi_bready |=> !s_axi_bvalid_ff) else $error("b");
	chk_read_done: assert property (
		s_axi_rvalid_ff && s_axi_rready |=> !s_axi_rvalid_ff) else $error("r");
	chk_pulse_due: assert property (
		hi_cnt_ff <= hi_max) else $error("test pulse overdue");
	chk_mismatch_react: assert property (
		mis_cnt_ff == mis_lim |-> safe_out_fault_ff) else $error("no fault");
endmodule // sotp_chk

bind sotp_safe_out sotp_chk #(.PERIOD_CYC(PERIOD_CYC), .REACT_CYC(REACT_CYC))
	i_sotp_chk (.aclk, .aresetn, .s_axi_arvalid,
	.s_axi_arready, .s_axi_bready, .s_axi_bvalid_ff, .s_axi_rready,
	.s_axi_rvalid_ff, .rdbk_a, .out_a_ff, .out_b_ff, .safe_out_fault_ff);

//--- sim/sotp_sdi_model.sv
module sotp_sdi_model (
	input wire aclk, // Clock.
	input wire aresetn, // Reset, active low.
	input wire out_a, // Channel A.
	input wire out_b, // Channel B.
	input wire stuck_lo_a, // Hold read-back A low.
	input wire stuck_hi_b, // Hold read-back B high.
	output logic rdbk_a_ff, // Read-back A.
	output logic rdbk_b_ff, // Read-back B.
	output logic seen_ff, // Filtered state.
	output logic [7:0] pulses_ff // Test pulses seen.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] low_cnt_ff;
	always_ff @(posedge aclk) begin
		rdbk_a_ff <= out_a && !stuck_lo_a;
		rdbk_b_ff <= out_b || stuck_hi_b;
		low_cnt_ff <= (out_a || low_cnt_ff == 8'hff) ? {8{!out_a}} & low_cnt_ff
			: low_cnt_ff + 8'h1;
		// Lows shorter than 150 cycles are test pulses, not state changes.
		if (out_a)
			seen_ff <= 1'b1;
		else if (low_cnt_ff > 8'd150)
			seen_ff <= 1'b0;
		if (!aresetn)
			pulses_ff <= 8'h0;
		else if (out_a && low_cnt_ff >= 8'd90 && low_cnt_ff <= 8'd110)
			pulses_ff <= pulses_ff + 8'h1;
	end
endmodule // sotp_sdi_model

//--- sim/sotp_safe_out_tb_top.sv
module sotp_safe_out_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, stuck_lo_a = 0, stuck_hi_b = 0;
	logic [5:0] fn_vec = '0;
	wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid_ff;
	wire s_axi_rvalid_ff, rdbk_a, rdbk_b, out_a_ff, out_b_ff, irq, sdi_seen;
	wire safe_out_fault_ff;
	wire [1:0] s_axi_bresp_ff, s_axi_rresp_ff;
	wire [31:0] s_axi_rdata_ff;
	wire [7:0] sdi_pulses;
	int mismatches = 0, checked = 0, cyc = 0, n;
	logic [31:0] d;
	logic [1:0] r;
	logic [1:0] b;
	// Shortened timing; the tolerance outlasts a pulse so that a read-back stuck
	// high is caught by the pulse check, not by the mismatch timer.
	localparam int PER_CYC = 2000;
	localparam int PUL_CYC = 100;
	localparam int REACT_CYC = 150;
	// Each row: selector code, function states, expected output level.
	logic [14:0] rows [12] = '{{8'h00, 6'h3f, 1'b0}, {8'h01, 6'h01, 1'b1},
		{8'h01, 6'h3e, 1'b0}, {8'h02, 6'h02, 1'b1}, {8'h03, 6'h04, 1'b1},
		{8'h04, 6'h08, 1'b1}, {8'h05, 6'h10, 1'b1}, {8'h05, 6'h2f, 1'b0},
		{8'h06, 6'h20, 1'b1}, {8'h06, 6'h1f, 1'b0}, {8'h07, 6'h00, 1'b1},
		{8'h08, 6'h3f, 1'b0}};

	sotp_safe_out #(.PERIOD_CYC(PER_CYC), .PULSE_CYC(PUL_CYC),
		.REACT_CYC(REACT_CYC)) i_sotp_safe_out (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp_ff, .s_axi_bvalid_ff,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata_ff, .s_axi_rresp_ff, .s_axi_rvalid_ff, .s_axi_rready,
		.fn_sto(fn_vec[0]), .fn_ss1(fn_vec[1]), .fn_sos(fn_vec[2]),
		.fn_ss2(fn_vec[3]), .fn_sls(fn_vec[4]), .fn_brake_rel(fn_vec[5]),
		.rdbk_a, .rdbk_b, .out_a_ff, .out_b_ff, .safe_out_fault_ff, .irq);
	sotp_sdi_model i_sotp_sdi_model (.aclk, .aresetn, .out_a(out_a_ff),
		.out_b(out_b_ff), .stuck_lo_a, .stuck_hi_b, .rdbk_a_ff(rdbk_a),
		.rdbk_b_ff(rdbk_b), .seen_ff(sdi_seen), .pulses_ff(sdi_pulses));

	initial forever #10 aclk = ~aclk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid_ff);
		b = s_axi_bresp_ff;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid_ff);
		d = s_axi_rdata_ff;
		r = s_axi_rresp_ff;
		s_axi_rready <= 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(8'h00);
		check(d, 32'h0);
		axi_rd(8'h20);
		check(32'(r), 32'h2);
		axi_wr(8'h20, 32'h0);
		check(32'(b), 32'h2);
		foreach (rows[i]) begin
			fn_vec <= rows[i][6:1];
			axi_wr(8'h00, 32'(rows[i][14:7]));
			repeat (4) @(posedge aclk);
			check(32'({out_a_ff, out_b_ff}), 32'({2{rows[i][0]}}));
		end
		axi_rd(8'h04);
		check(d, 32'h3f);
		axi_wr(8'h10, 32'h4);
		check(32'(b), 32'h0);
		axi_wr(8'h00, 32'h7);
		n = 0;
		while (!out_a_ff) @(posedge aclk);
		while (out_a_ff) begin
			@(posedge aclk);
			n++;
		end
		check(32'(n > PER_CYC * 9 / 10 && n <= PER_CYC * 11 / 10), 32'h1);
		n = 0;
		while (!out_a_ff) begin
			@(posedge aclk);
			n++;
		end
		check(32'(n >= PUL_CYC * 9 / 10 && n <= PUL_CYC * 11 / 10), 32'h1);
		repeat (5) @(posedge aclk);
		check(32'({sdi_seen, sdi_pulses}), 32'h101);
		check(32'(irq), 32'h1);
		axi_wr(8'h10, 32'h0);
		check(32'(irq), 32'h0);
		axi_wr(8'h0c, 32'h4);
		axi_wr(8'h10, 32'h4);
		check(32'(irq), 32'h0);
		stuck_hi_b <= 1'b1;
		while (!safe_out_fault_ff) @(posedge aclk);
		repeat (3) @(posedge aclk);
		check(32'({out_a_ff, out_b_ff}), 32'h0);
		axi_rd(8'h0c);
		check(32'(d[2:0]), 32'h6);
		axi_rd(8'h08);
		check(d, 32'h31);
		aresetn <= 1'b0;
		stuck_hi_b <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		check(32'(safe_out_fault_ff), 32'h0);
		axi_wr(8'h00, 32'h7);
		repeat (5) @(posedge aclk);
		stuck_lo_a <= 1'b1;
		n = 0;
		while (!safe_out_fault_ff && n < REACT_CYC + 100) begin
			@(posedge aclk);
			n++;
		end
		check(32'(n <= REACT_CYC + 5), 32'h1);
		tally_and_finish();
	end
endmodule // sotp_safe_out_tb_top
